// File: design/audio_rx_channels.sv
/*
 * Stereo serial-audio receiver: several channels sampling a data line
 * framed by word and bit clocks, each feeding an eight-pair queue read
 * over a plain register port (read data one cycle after the strobe).
 * Assumes the audio pins are asynchronous to clk_sys_i, that the bit
 * clock is well below a quarter of clk_sys_i, and that the transmit
 * block supplies its enable and clock configuration on clk_sys_i.
 */
// Chosen here: the address map and the address-and-strobe port.
//
// Summary of operation
// R01: Three receive channels, slave or master clocks
// R02: Word length 16, 24 or 32 bits
// R03: Programmable word, bit clock polarity, sample edge
// R04: Delayed first bit, justification, bit order
// R05: Queue of eight left/right pairs per channel
// R06: Software sets global enable before use
// R07: After enable wait for next left word
// R08: Word boundaries move shift registers to data
// R09: Complete pair written at next location, if not full
// R10: Location freed after both halves read
// R11: Empty read repeats last data, flags underflow
// R12: First empty read after reset returns zero
// R13: Pair into full queue dropped, marker set
// R14: Overflow shows when reads reach marked location
// R15: Overflow clears on reading marked pair
// R16: Short samples right justified, upper bits zero
// R17: Software disables channels before reconfiguring
// R18: Five status bits per queue in status
// R19: Half flag at four or fewer pairs
// R20: Full flag at eight pairs
// R21: Master clock config from receive settings
// R22: Software matches receive and transmit clock settings
// R23: Pairs cross into bus domain without loss
`timescale 1ns/1ps
`default_nettype none

module audio_rx_channels #(
   parameter int CHANNELS = 3
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic [CHANNELS-1:0] slave_sclk_i,
   input wire logic [CHANNELS-1:0] slave_lrck_i,
   input wire logic mstr_sclk_i,
   input wire logic mstr_lrck_i,
   input wire logic [CHANNELS-1:0] sdata_i,
   input wire logic tx_enable_i,
   input wire logic [6:0] tx_clock_config_i,
   output logic [6:0] mstr_clk_cfg_o
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   initial begin
      if (CHANNELS < 1 || CHANNELS > 6) begin
         $error("CHANNELS must be 1 to 6");
      end
   end

   localparam int SW = 3 * CHANNELS + 2;

   // ----------------------------------------------------------------
   // Global registers
   // ----------------------------------------------------------------
   logic glob_en;
   logic [6:0] rx_clock_config;
   logic wr_gctl;
   logic wr_cfg;
   logic [1:0] wlen;
   logic master;
   logic sclk_pol;

   assign wr_gctl = wr_i && addr_i == audio_rx_pkg::OFS_GLOBAL_CONTROL;
   assign wr_cfg = wr_i && addr_i == audio_rx_pkg::OFS_RX_CLOCK_CONFIG;
   assign wlen = rx_clock_config[audio_rx_pkg::CFG_WLEN_LSB +: 2];
   assign master = rx_clock_config[audio_rx_pkg::CFG_MASTER_BIT];
   assign sclk_pol = rx_clock_config[audio_rx_pkg::CFG_SCLK_POL_BIT];

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         glob_en <= 1'b0;
      end else if (wr_gctl) begin
         glob_en <= wdata_i[audio_rx_pkg::GCTL_ENABLE_BIT];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rx_clock_config <= audio_rx_pkg::CFG_RESET;
      end else if (wr_cfg) begin
         rx_clock_config <= wdata_i[audio_rx_pkg::CFG_WIDTH-1:0];
      end
   end

   // Clock configuration to the audio clock generator
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mstr_clk_cfg_o <= audio_rx_pkg::CFG_RESET;
      end else if (tx_enable_i) begin
         mstr_clk_cfg_o <= tx_clock_config_i; // R22
      end else if (master) begin
         mstr_clk_cfg_o <= rx_clock_config; // R21
      end else begin
         mstr_clk_cfg_o <= audio_rx_pkg::CFG_RESET;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [SW-1:0] sync_a;
   logic [SW-1:0] sync_b;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {mstr_lrck_i, mstr_sclk_i, sdata_i, slave_lrck_i,
                    slave_sclk_i}; // R23
         sync_b <= sync_a;
      end
   end

   // ----------------------------------------------------------------
   // Word helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] shift_in(input logic [31:0] sh,
                                            input logic b,
                                            input logic lsb);
      shift_in = lsb ? {b, sh[31:1]} : {sh[30:0], b};
   endfunction

   function automatic logic [31:0] finish(input logic [31:0] sh,
                                          input logic [1:0] wl,
                                          input logic lsb);
      logic [31:0] r;
      r = sh;
      case (wl) // R16
         audio_rx_pkg::WLEN_16: r = lsb ? {16'h0000, sh[31:16]} :
                                          {16'h0000, sh[15:0]};
         audio_rx_pkg::WLEN_24: r = lsb ? {8'h00, sh[31:8]} :
                                          {8'h00, sh[23:0]};
         default: r = sh;
      endcase
      finish = r;
   endfunction

   logic [5:0] wl_bits;
   always_comb begin
      case (wlen) // R02
         audio_rx_pkg::WLEN_16: wl_bits = audio_rx_pkg::BITS_16;
         audio_rx_pkg::WLEN_24: wl_bits = audio_rx_pkg::BITS_24;
         default: wl_bits = audio_rx_pkg::BITS_32;
      endcase
   end

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   logic [31:0] ch_rdata [CHANNELS];
   logic [CHANNELS-1:0] ch_hit;
   logic [CHANNELS*audio_rx_pkg::STATUS_BITS-1:0] status;

   genvar c;
   generate
      for (c = 0; c < CHANNELS; c++) begin : g_ch
         audio_rx_pkg::chan_ctrl_s ctrl;
         audio_rx_pkg::rx_state_e state;
         audio_rx_pkg::pair_s mem [audio_rx_pkg::QUEUE_PAIRS];
         logic sel;
         logic rd_left;
         logic rd_right;
         logic sclk_e;
         logic sclk_q;
         logic samp;
         logic lr;
         logic lr_q;
         logic side;
         logic side_q;
         logic bit_in;
         logic accept;
         logic [5:0] cnt;
         logic [31:0] lsh;
         logic [31:0] rsh;
         logic [31:0] left_data;
         logic pair_v;
         audio_rx_pkg::pair_s pair;
         logic [2:0] wr_ptr;
         logic [2:0] rd_ptr;
         logic [3:0] count;
         logic [3:0] next_count;
         logic got_left;
         logic got_right;
         logic free;
         logic empty;
         logic full;
         logic push;
         logic [31:0] last_left;
         logic [31:0] last_right;
         logic underflow;
         logic ovf_armed;
         logic [2:0] ovf_mark;
         logic ovf_flag;

         assign sel = addr_i[7:4] == audio_rx_pkg::CH_BASE_NIBBLE +
                      4'(c);
         assign rd_left = rd_i && sel &&
                          addr_i[3:0] == audio_rx_pkg::OFS_LEFT_PORT;
         assign rd_right = rd_i && sel &&
                           addr_i[3:0] == audio_rx_pkg::OFS_RIGHT_PORT;

         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
               ctrl <= audio_rx_pkg::CTRL_RESET;
            end else if (wr_i && sel &&
                         addr_i[3:0] == audio_rx_pkg::OFS_CHAN_CTRL) begin
               ctrl <= wdata_i[5:0]; // R17
            end
         end

         // Serial framing
         assign sclk_e = (master ? sync_b[SW-2] : sync_b[c]) ^
                         sclk_pol; // R01 R03
         assign lr = (master ? sync_b[SW-1] : sync_b[CHANNELS + c]) ^
                     ctrl.lrck_pol; // R03
         assign bit_in = sync_b[2*CHANNELS + c];
         assign samp = ctrl.sample_fall ? (sclk_q & ~sclk_e) :
                                          (~sclk_q & sclk_e); // R03
         assign side = ctrl.one_bit_delay ? lr_q : lr; // R04
         assign accept = ctrl.right_just || cnt < wl_bits; // R04

         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
               sclk_q <= 1'b0;
               lr_q <= 1'b0;
               side_q <= 1'b0;
            end else begin
               sclk_q <= sclk_e;
               if (samp) begin
                  lr_q <= lr;
                  side_q <= side;
               end
            end
         end

         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i || !glob_en || !ctrl.enable) begin
               state <= audio_rx_pkg::RX_WAIT;
               cnt <= '0;
               lsh <= '0;
               rsh <= '0;
               left_data <= '0;
               pair_v <= 1'b0;
               pair <= '0;
            end else begin
               pair_v <= 1'b0;
               if (samp) begin
                  unique case (state)
                     audio_rx_pkg::RX_WAIT: begin
                        if (side_q && !side) begin
                           state <= audio_rx_pkg::RX_LEFT; // R07
                           lsh <= shift_in('0, bit_in, ctrl.lsb_first);
                           cnt <= 6'h01;
                        end
                     end
                     audio_rx_pkg::RX_LEFT: begin
                        if (side) begin
                           left_data <= finish(lsh, wlen,
                                               ctrl.lsb_first); // R08
                           rsh <= shift_in('0, bit_in, ctrl.lsb_first);
                           cnt <= 6'h01;
                           state <= audio_rx_pkg::RX_RIGHT;
                        end else if (accept) begin
                           lsh <= shift_in(lsh, bit_in, ctrl.lsb_first);
                           cnt <= cnt == audio_rx_pkg::CNT_MAX ? cnt :
                                  cnt + 6'h01;
                        end
                     end
                     audio_rx_pkg::RX_RIGHT: begin
                        if (!side) begin
                           pair <= {left_data,
                                    finish(rsh, wlen, ctrl.lsb_first)};
                           pair_v <= 1'b1; // R08 R23
                           lsh <= shift_in('0, bit_in, ctrl.lsb_first);
                           cnt <= 6'h01;
                           state <= audio_rx_pkg::RX_LEFT;
                        end else if (accept) begin
                           rsh <= shift_in(rsh, bit_in, ctrl.lsb_first);
                           cnt <= cnt == audio_rx_pkg::CNT_MAX ? cnt :
                                  cnt + 6'h01;
                        end
                     end
                     default: state <= audio_rx_pkg::RX_WAIT;
                  endcase
               end
            end
         end

         // Queue of pairs
         assign empty = count == '0;
         assign full = count == audio_rx_pkg::FULL_LEVEL;
         assign push = pair_v && !full; // R13
         assign free = (got_left || rd_left) && (got_right || rd_right) &&
                       !empty; // R10
         always_comb begin
            next_count = count;
            if (push && !free) begin
               next_count = count + 4'h1;
            end else if (free && !push) begin
               next_count = count - 4'h1;
            end
         end

         always_ff @(posedge clk_sys_i) begin
            if (push) begin
               mem[wr_ptr] <= pair; // R05 R09
            end
         end

         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i || !glob_en) begin
               wr_ptr <= '0;
               rd_ptr <= '0;
               count <= '0;
               got_left <= 1'b0;
               got_right <= 1'b0;
            end else begin
               count <= next_count;
               if (push) begin
                  wr_ptr <= wr_ptr + 3'h1; // R09
               end
               if (free) begin
                  rd_ptr <= rd_ptr + 3'h1; // R10
                  got_left <= 1'b0;
                  got_right <= 1'b0;
               end else if (!empty) begin
                  got_left <= got_left | rd_left;
                  got_right <= got_right | rd_right;
               end
            end
         end

         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i || !glob_en) begin
               last_left <= '0; // R12
               last_right <= '0;
            end else begin
               if (rd_left && !empty) begin
                  last_left <= mem[rd_ptr].left;
               end
               if (rd_right && !empty) begin
                  last_right <= mem[rd_ptr].right;
               end
            end
         end

         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i || !glob_en) begin
               underflow <= 1'b0;
            end else if ((rd_left || rd_right) && empty) begin
               underflow <= 1'b1; // R11
            end else if (push) begin
               underflow <= 1'b0;
            end
         end

         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i || !glob_en) begin
               ovf_armed <= 1'b0;
               ovf_mark <= '0;
            end else if (pair_v && full && !ovf_armed) begin
               ovf_armed <= 1'b1; // R13
               ovf_mark <= wr_ptr - 3'h1;
            end else if (free && ovf_flag) begin
               ovf_armed <= 1'b0; // R15
            end
         end

         assign ovf_flag = ovf_armed && rd_ptr == ovf_mark; // R14

         assign ch_rdata[c] = rd_left ?
                              (empty ? last_left : mem[rd_ptr].left) :
                              (rd_right ?
                               (empty ? last_right : mem[rd_ptr].right) :
                               {26'h0, ctrl}); // R11
         assign ch_hit[c] = sel;
         assign status[c*audio_rx_pkg::STATUS_BITS +: 5] =
            {count <= audio_rx_pkg::HALF_LEVEL ? {full, 1'b1} :
                                                 {full, 1'b0},
             empty, ovf_flag, underflow}; // R18 R19 R20
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      if (addr_i == audio_rx_pkg::OFS_GLOBAL_CONTROL) begin
         next_rdata = {31'h0, glob_en}; // R06
      end else if (addr_i == audio_rx_pkg::OFS_GLOBAL_STATUS) begin
         next_rdata = 32'(status); // R18
      end else if (addr_i == audio_rx_pkg::OFS_RX_CLOCK_CONFIG) begin
         next_rdata = {25'h0, rx_clock_config};
      end
      for (int i = 0; i < CHANNELS; i++) begin
         if (ch_hit[i]) begin
            next_rdata = ch_rdata[i];
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= rd_i ? next_rdata : '0;
      end
   end

endmodule

`default_nettype wire

// File: design/audio_rx_pkg.sv
/*
 * Shared constants and types for the stereo serial-audio receive block:
 * register offsets, field positions, reset values, word-length codes,
 * receiver states and the carriers for sample pairs and channel control.
 * Assumes a 100 MHz bus clock and byte addresses on an 8-bit register port.
 */
package audio_rx_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_GLOBAL_CONTROL = 8'h00;
   localparam logic [7:0] OFS_GLOBAL_STATUS = 8'h04;
   localparam logic [7:0] OFS_RX_CLOCK_CONFIG = 8'h08;
   localparam logic [3:0] CH_BASE_NIBBLE = 4'h1;
   localparam logic [3:0] OFS_LEFT_PORT = 4'h0;
   localparam logic [3:0] OFS_RIGHT_PORT = 4'h4;
   localparam logic [3:0] OFS_CHAN_CTRL = 4'h8;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int GCTL_ENABLE_BIT = 0;
   localparam int CFG_MASTER_BIT = 0;
   localparam int CFG_WLEN_LSB = 1;
   localparam int CFG_SCLK_POL_BIT = 3;
   localparam int CFG_WIDTH = 7;
   localparam int STATUS_BITS = 5;
   localparam int ST_UNDER = 0;
   localparam int ST_OVER = 1;
   localparam int ST_EMPTY = 2;
   localparam int ST_HALF = 3;
   localparam int ST_FULL = 4;
   localparam logic [6:0] CFG_RESET = 7'h00;
   localparam logic [5:0] CTRL_RESET = 6'h00;

   // ----------------------------------------------------------------
   // Word lengths and queue thresholds
   // ----------------------------------------------------------------
   localparam logic [1:0] WLEN_16 = 2'h0;
   localparam logic [1:0] WLEN_24 = 2'h1;
   localparam logic [5:0] BITS_16 = 6'h10;
   localparam logic [5:0] BITS_24 = 6'h18;
   localparam logic [5:0] BITS_32 = 6'h20;
   localparam logic [5:0] CNT_MAX = 6'h3f;
   localparam int QUEUE_PAIRS = 8;
   localparam logic [3:0] HALF_LEVEL = 4'h4;
   localparam logic [3:0] FULL_LEVEL = 4'h8;
   localparam int SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      RX_WAIT = 3'b001,
      RX_LEFT = 3'b010,
      RX_RIGHT = 3'b100
   } rx_state_e;

   typedef struct packed {
      logic [31:0] left;
      logic [31:0] right;
   } pair_s;

   typedef struct packed {
      logic lsb_first;
      logic right_just;
      logic one_bit_delay;
      logic sample_fall;
      logic lrck_pol;
      logic enable;
   } chan_ctrl_s;

endpackage

// File: testbench/audio_rx_chk.sv
/*
 * Checker for the receive block: status, sample and generator-config
 * relations seen at the top module's ports.
 * Assumes one bus clock domain and the register map of the package.
 */
`timescale 1ns/1ps
`default_nettype none

module audio_rx_chk (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic tx_enable_i,
   input wire logic [6:0] tx_clock_config_i,
   input wire logic [6:0] mstr_clk_cfg_o
);
   // ----------------------------------------------------------------
   // Shadow registers
   // ----------------------------------------------------------------
   logic [6:0] rx_cfg;
   logic glob_en;
   logic st_rd;
   logic dat_rd;

   assign st_rd = rd_i && addr_i == 8'h04;
   assign dat_rd = rd_i && addr_i[7:4] == 4'h1 && !addr_i[3];

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i)
         rx_cfg <= 7'h00;
      else if (wr_i && addr_i == 8'h08)
         rx_cfg <= wdata_i[6:0];
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i)
         glob_en <= 1'b0;
      else if (wr_i && addr_i == 8'h00)
         glob_en <= wdata_i[0];
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   property p_cfg_tx;
      tx_enable_i |=> mstr_clk_cfg_o == $past(tx_clock_config_i);
   endproperty
   a_cfg_tx: assert property (p_cfg_tx)
      else $error("generator config not from transmit side");

   property p_cfg_rx;
      !tx_enable_i && rx_cfg[0] |=> mstr_clk_cfg_o == $past(rx_cfg);
   endproperty
   a_cfg_rx: assert property (p_cfg_rx)
      else $error("generator config not from receive side");

   property p_cfg_off;
      !tx_enable_i && !rx_cfg[0] |=> mstr_clk_cfg_o == 7'h00;
   endproperty
   a_cfg_off: assert property (p_cfg_off)
      else $error("generator config not zero");

   property p_short16;
      dat_rd && rx_cfg[2:1] == 2'h0 |=> rdata_o[31:16] == 16'h0000;
   endproperty
   a_short16: assert property (p_short16)
      else $error("upper bits of short sample not zero");

   property p_short24;
      dat_rd && rx_cfg[2:1] == 2'h1 |=> rdata_o[31:24] == 8'h00;
   endproperty
   a_short24: assert property (p_short24)
      else $error("upper bits of 24-bit sample not zero");

   property p_full_half;
      st_rd |=> !rdata_o[4] || !rdata_o[3];
   endproperty
   a_full_half: assert property (p_full_half)
      else $error("half flag with full queue");

   property p_empty_half;
      st_rd ##1 rdata_o[2] |-> rdata_o[3];
   endproperty
   a_empty_half: assert property (p_empty_half)
      else $error("half flag missing on empty queue");

   property p_empty_full;
      st_rd |=> !(rdata_o[2] && rdata_o[4]);
   endproperty
   a_empty_full: assert property (p_empty_full)
      else $error("empty and full together");

   property p_over;
      st_rd ##1 rdata_o[1] |-> !rdata_o[2];
   endproperty
   a_over: assert property (p_over)
      else $error("overflow shown on empty queue");

   property p_off_empty;
      st_rd && !glob_en |=> rdata_o[2] && !rdata_o[4];
   endproperty
   a_off_empty: assert property (p_off_empty)
      else $error("queue not empty while disabled");
endmodule

bind audio_rx_channels audio_rx_chk i_audio_rx_chk (
   .clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .tx_enable_i, .tx_clock_config_i, .mstr_clk_cfg_o
);

`default_nettype wire

// File: testbench/codec_model.sv
/*
 * Behavioural stereo codec: bit clock, word clock and serial data.
 * Assumes the receiver samples on the rising bit-clock edge, left
 * word while the word clock is low; bit clock idles low.
 */
`timescale 1ns/1ps
`default_nettype none

module codec_model (
   output logic sclk_o,
   output logic lrck_o,
   output logic sdata_o
);
   // ----------------------------------------------------------------
   // Bit and frame tasks
   // ----------------------------------------------------------------
   initial begin
      sclk_o = 1'b0;
      lrck_o = 1'b1;
      sdata_o = 1'b0;
   end

   // Lines move mid low phase, well clear of the sampled rise
   task automatic send_bit(input logic side, input logic b);
      #20;
      lrck_o <= side;
      sdata_o <= b;
      #20;
      sclk_o <= 1'b1;
      #40;
      sclk_o <= 1'b0;
   endtask

   // One right bit so that the next left word has a start
   task automatic prime();
      send_bit(1'b1, 1'b0);
      sdata_o <= ~sdata_o;
   endtask

   // Word n bits MSB first, then one set pad bit opening the next left
   task automatic frame(input logic [31:0] l, input logic [31:0] r,
                        input int n);
      for (int i = n - 1; i >= 0; i--)
         send_bit(1'b0, l[i]);
      for (int i = n - 1; i >= 0; i--)
         send_bit(1'b1, r[i]);
      send_bit(1'b0, 1'b1);
      sdata_o <= ~sdata_o;
   endtask
endmodule

`default_nettype wire

// File: testbench/audio_rx_channels_bench.sv
/*
 * Testbench for the receive block: register-port tasks, one codec
 * model feeding every channel's pins, checks on channels 0 and 1.
 * Assumes a 100 MHz bus clock and an 80 ns bit clock.
 */
`timescale 1ns/1ps
`default_nettype none

module audio_rx_channels_bench;
   logic clk_sys_i;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic tx_enable_i = 1'b0;
   logic [6:0] tx_clock_config_i = 7'h2a;
   logic [6:0] mstr_clk_cfg_o;
   logic sclk;
   logic lrck;
   logic sdata;
   logic [31:0] v;
   logic [31:0] m;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   int nb [3] = '{32, 24, 16};

   // ----------------------------------------------------------------
   // Design, codec and clock
   // ----------------------------------------------------------------
   codec_model i_codec_model (.sclk_o(sclk), .lrck_o(lrck),
      .sdata_o(sdata));

   audio_rx_channels i_audio_rx_channels (
      .clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .slave_sclk_i({3{sclk}}), .slave_lrck_i({3{lrck}}),
      .mstr_sclk_i(sclk), .mstr_lrck_i(lrck), .sdata_i({3{sdata}}),
      .tx_enable_i, .tx_clock_config_i, .mstr_clk_cfg_o
   );

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         bad_count++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(negedge clk_sys_i);
      d = rdata_o;
   endtask

   task automatic rd_st(input logic [4:0] e);
      rd_reg(8'h04, v);
      chk("status", {27'h0, v[4:0]}, {27'h0, e});
   endtask

   task automatic gen_chk(input logic [6:0] e);
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk("gen cfg", {25'h0, mstr_clk_cfg_o}, {25'h0, e});
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd_st(5'b01100);
      wr_reg(8'h00, 32'h1);
      rd_reg(8'h10, v);
      chk("first left", v, 32'h0);
      rd_st(5'b01101);
      wr_reg(8'h08, 32'h65);
      gen_chk(7'h65);
      @(posedge clk_sys_i);
      tx_enable_i <= 1'b1;
      gen_chk(7'h2a);
      @(posedge clk_sys_i);
      tx_enable_i <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         wr_reg(8'h18, 32'h10);
         wr_reg(8'h08, 32'(2 - k) << 1);
         wr_reg(8'h18, 32'h11);
         if (k == 2)
            wr_reg(8'h28, 32'h21);
         i_codec_model.prime();
         i_codec_model.frame(32'hc3a5_9e17 + k, 32'h7b1d_48e6 - k, nb[k]);
         repeat (10) @(posedge clk_sys_i);
         m = 32'hffff_ffff >> (32 - nb[k]);
         rd_reg(8'h10, v);
         chk("left", v, (32'hc3a5_9e17 + k) & m);
         rd_reg(8'h14, v);
         chk("right", v, (32'h7b1d_48e6 - k) & m);
         if (k == 2) begin
            rd_reg(8'h20, v);
            chk("lsb left", v, 32'h9879);
            rd_reg(8'h24, v);
            chk("lsb right", v, 32'h2712);
         end
      end
      for (int k = 0; k < 9; k++)
         i_codec_model.frame(32'h1000 + k, 32'h2000 + k, 16);
      repeat (10) @(posedge clk_sys_i);
      rd_st(5'b10000);
      for (int k = 0; k < 8; k++) begin
         if (k == 4)
            rd_st(5'b01000);
         if (k == 7)
            rd_st(5'b01010);
         rd_reg(8'h10, v);
         chk("queued left", v, 32'h1000 + k);
         if (k == 0)
            rd_st(5'b10000);
         rd_reg(8'h14, v);
         chk("queued right", v, 32'h2000 + k);
      end
      rd_st(5'b01100);
      rd_reg(8'h10, v);
      chk("stale left", v, 32'h1007);
      rd_st(5'b01101);
      rd_reg(8'hf0, v);
      chk("unmapped", v, 32'h0);
      wr_reg(8'h00, 32'h0);
      rd_st(5'b01100);
      wrap_up();
   end
endmodule

`default_nettype wire
